/* verilog/fpil_top.sv */
// Fault protection, interrupt flags and general outputs with AXI4-Lite registers
`timescale 1ns/100ps
module fpil_top #(
	parameter int QUAL_CYC = fpil_pkg::CYC_QUAL
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire fpil_pkg::fpil_ana_t anaIn,
	input wire logic [1:0] buckRamp,
	input wire logic [47:0] otpCode,
	input wire logic otpCodeValid,
	output logic irqOutN,
	output logic [2:0] convRun,
	output logic [2:0] switchHiZ,
	output logic [2:0] dischargeOn,
	output logic [5:0] buckPeakLimitSel,
	output logic [1:0] boostPeakLimitSel,
	output logic hotWarningThresholdSel,
	output logic [2:0] genoutO,
	output logic [2:0] genoutOe,
	output logic out1FunctionSel,
	output logic out2FunctionSel,
	output logic [5:0] pgGood,
	output fpil_pkg::fpil_state_t deviceState,
	output logic [47:0] otpFixed
);
	localparam int NA = $bits(fpil_pkg::fpil_ana_t);
	localparam int CW = $clog2(QUAL_CYC + 1);
	localparam logic [CW-1:0] QEND = CW'(QUAL_CYC - 1);
	localparam logic [CW-1:0] QDONE = CW'(QUAL_CYC);

	fpil_pkg::fpil_ctrl_t ctrlR;
	fpil_pkg::fpil_flags_t flagsR;
	fpil_pkg::fpil_flags_t flagSet;
	fpil_pkg::fpil_flags_t flagClr;
	fpil_pkg::fpil_flags_t irqEn;
	fpil_pkg::fpil_gen_t genR;
	fpil_pkg::fpil_mask_t maskR;
	fpil_pkg::fpil_ana_t ana;
	logic [7:0] limitR;
	logic [NA-1:0] s1_r, s2_r, s3_r, syn_r;
	logic [fpil_pkg::NDB-1:0] dbRaw, dbOut;
	logic [2:0] lowV, fault, climitSet, climitLive, runNxt;
	logic [2:0] rampV;
	logic ovpLive, sdLive, warnLive, warnPrev_r, uvlo, blockAll, softReset;
	logic eccSingle_r, eccDouble_r;
	logic [fpil_pkg::SYN_W-1:0] syn;
	logic par;
	logic awHeld_r, wHeld_r, bvalid_r, rvalid_r, doWrite;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r, bm, rdNxt, rdata_r;
	logic [3:0] wStrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [5:0] wrDec;
	logic [16:0] liveV;
	logic irqN_r;
	logic [2:0] genO_r, genOe_r, genLvl;
	fpil_pkg::fpil_state_t state_r;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// A level counts once the second and third stage agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			syn_r <= '0;
		end else if (ce) begin
			s1_r <= anaIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			syn_r <= (s2_r == s3_r) ? s3_r : syn_r;
		end
	end
	assign ana = syn_r;
	assign uvlo = ana.underVolt;

	// ------------------------------------------------------------
	// Debounce counters
	// ------------------------------------------------------------
	assign dbRaw = {ana.slowPg, ana.buckPg, ana.boostPeak, ana.buckPeak, ana.hotShut, ana.hotWarn, ana.overVolt};
	genvar g;
	generate
		for (g = 0; g < fpil_pkg::NDB; g++) begin : gDb
			localparam logic [9:0] LEN = 10'(fpil_pkg::dbLen(g));
			logic [9:0] cnt_r;
			logic lv_r;
			// Both edges need the same length, so a glitch only restarts the count
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cnt_r <= '0;
					lv_r <= 1'b0;
				end else if (ce) begin
					if (dbRaw[g] == lv_r) begin
						cnt_r <= '0;
					end else if (cnt_r == LEN - 10'h001) begin
						cnt_r <= '0;
						lv_r <= dbRaw[g];
					end else begin
						cnt_r <= cnt_r + 10'h001;
					end
				end
			end
			assign dbOut[g] = lv_r;
		end
	endgenerate
	assign ovpLive = dbOut[fpil_pkg::DB_OVP];
	assign warnLive = dbOut[fpil_pkg::DB_OVP + 1];
	assign sdLive = dbOut[fpil_pkg::DB_SD];
	assign climitLive = dbOut[fpil_pkg::DB_BOOST:fpil_pkg::DB_CLIM];
	assign pgGood = dbOut[fpil_pkg::NDB-1:fpil_pkg::DB_PGF];

	// ------------------------------------------------------------
	// Converter control
	// ------------------------------------------------------------
	assign blockAll = ovpLive | flagsR.overVolt | sdLive | flagsR.hotShut | uvlo;
	assign lowV = {ana.boostBelowIn | ana.boostHardLow, ana.fbLow};
	assign rampV = {1'b0, buckRamp};
	genvar c;
	generate
		for (c = 0; c < 3; c++) begin : gConv
			logic run_r, hiz_r, dis_r, pk_r, starting, supp;
			logic [CW-1:0] startCnt_r, lowCnt_r;
			assign starting = run_r & (startCnt_r != QDONE);
			// Boost current limit is not gated by start-up
			assign supp = (c < 2) & (starting | rampV[c]);
			assign fault[c] = run_r & lowV[c] & ((startCnt_r == QEND) | (~starting & (lowCnt_r == QEND)));
			assign runNxt[c] = ctrlR.convEn[c] & ~flagsR.shortF[c] & ~blockAll & ~fault[c];
			assign climitSet[c] = climitLive[c] & ~pk_r & ~supp;
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					run_r <= 1'b0;
					pk_r <= 1'b0;
				end else if (ce) begin
					run_r <= runNxt[c];
					pk_r <= climitLive[c];
				end
			end
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					startCnt_r <= '0;
					lowCnt_r <= '0;
				end else if (ce) begin
					startCnt_r <= ~run_r ? '0 : (starting ? startCnt_r + 1'b1 : startCnt_r);
					lowCnt_r <= (~run_r | ~lowV[c]) ? '0 : (lowCnt_r == QEND ? lowCnt_r : lowCnt_r + 1'b1);
				end
			end
			// Hard low on boost kills switching without the qualifying wait
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					hiz_r <= 1'b1;
					dis_r <= 1'b0;
				end else if (ce) begin
					hiz_r <= ~runNxt[c] | ((c == 2) & ana.boostHardLow);
					dis_r <= ~runNxt[c] & ((ctrlR.dischargeEn[c] & (flagsR.shortF[c] | fault[c] | blockAll)) | ovpLive | uvlo);
				end
			end
			assign convRun[c] = run_r;
			assign switchHiZ[c] = hiz_r;
			assign dischargeOn[c] = dis_r;
		end
	endgenerate

	// ------------------------------------------------------------
	// Interrupt flags
	// ------------------------------------------------------------
	assign softReset = uvlo | ctrlR.swReset;
	always_comb begin
		flagSet = '0;
		flagSet.climit = climitSet;
		flagSet.shortF = fault;
		flagSet.buckGroup = |fault[1:0];
		flagSet.boostGroup = fault[2];
		flagSet.hotWarn = warnLive & ~warnPrev_r;
		flagSet.overVolt = ovpLive;
		flagSet.hotShut = sdLive;
		flagClr = (doWrite & wrDec[2]) ? fpil_pkg::fpil_flags_t'(wData_r[11:0] & bm[11:0]) : '0;
		irqEn = '1;
		irqEn.hotWarn = ~maskR.hotMask;
		irqEn.rstFlag = ~maskR.rstMask;
	end
	// Set wins over a clear in the same cycle, so a live fault keeps its flag
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flagsR <= fpil_pkg::FLAGS_SRST;
			warnPrev_r <= 1'b0;
		end else if (ce) begin
			warnPrev_r <= warnLive;
			if (softReset) begin
				flagsR <= (~fpil_pkg::MASK_RST.rstMask ? fpil_pkg::FLAGS_SRST : '0) | flagSet;
			end else begin
				flagsR <= flagSet | (flagsR & ~flagClr);
			end
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqN_r <= 1'b1;
		end else if (ce) begin
			irqN_r <= ~|(flagsR & irqEn);
		end
	end
	assign irqOutN = irqN_r;

	// ------------------------------------------------------------
	// Device state
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= fpil_pkg::ST_SHUTDOWN;
		end else if (ce) begin
			case (state_r)
				fpil_pkg::ST_SHUTDOWN: state_r <= uvlo ? fpil_pkg::ST_SHUTDOWN : fpil_pkg::ST_STANDBY;
				fpil_pkg::ST_STANDBY: state_r <= uvlo ? fpil_pkg::ST_SHUTDOWN : (|runNxt ? fpil_pkg::ST_ACTIVE : state_r);
				fpil_pkg::ST_ACTIVE: state_r <= uvlo ? fpil_pkg::ST_SHUTDOWN : (|runNxt ? state_r : fpil_pkg::ST_STANDBY);
				default: state_r <= fpil_pkg::ST_SHUTDOWN;
			endcase
		end
	end
	assign deviceState = state_r;

	// ------------------------------------------------------------
	// OTP error correction
	// ------------------------------------------------------------
	function automatic logic [fpil_pkg::SYN_W-1:0] eccSyn(input logic [47:0] cw);
		logic [fpil_pkg::SYN_W-1:0] s;
		s = '0;
		for (int i = 1; i < fpil_pkg::OTP_CW; i++) begin
			if (cw[i]) s = s ^ fpil_pkg::SYN_W'(i);
		end
		return s;
	endfunction : eccSyn
	assign syn = eccSyn(otpCode);
	assign par = ^otpCode;
	// Status only resets with a software reset or undervoltage, so an old error stays visible
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			eccSingle_r <= 1'b0;
			eccDouble_r <= 1'b0;
			otpFixed <= '0;
		end else if (ce) begin
			if (softReset) begin
				eccSingle_r <= 1'b0;
				eccDouble_r <= 1'b0;
			end else if (otpCodeValid) begin
				eccSingle_r <= eccSingle_r | par;
				eccDouble_r <= eccDouble_r | (~par & (syn != '0));
				otpFixed <= otpCode ^ (par ? (48'h1 << syn) : 48'h0);
			end
		end
	end

	// ------------------------------------------------------------
	// General outputs
	// ------------------------------------------------------------
	assign genLvl = (genR.seqCtrl & ana.seqPin) | (~genR.seqCtrl & genR.level);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			genO_r <= '0;
			genOe_r <= '0;
		end else if (ce) begin
			genO_r <= (ovpLive | flagsR.overVolt) ? 3'h0 : genLvl;
			genOe_r <= (genR.driveType & ~genLvl | ~genR.driveType) & {~genR.out2Sel, ~genR.out1Sel, 1'b1};
		end
	end
	assign genoutO = genO_r;
	assign genoutOe = genOe_r;
	assign out1FunctionSel = genR.out1Sel;
	assign out2FunctionSel = genR.out2Sel;
	assign buckPeakLimitSel = limitR[5:0];
	assign boostPeakLimitSel = limitR[7:6];
	assign hotWarningThresholdSel = ctrlR.hotSel;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	function automatic logic [5:0] regDec(input logic [7:0] a);
		regDec = {a == fpil_pkg::A_GEN, a == fpil_pkg::A_MASK, a == fpil_pkg::A_LIVE,
			a == fpil_pkg::A_FLAGS, a == fpil_pkg::A_LIMIT, a == fpil_pkg::A_CTRL};
	endfunction : regDec
	assign awready = ~awHeld_r & ~bvalid_r;
	assign wready = ~wHeld_r & ~bvalid_r;
	assign arready = ~rvalid_r;
	assign doWrite = awHeld_r & wHeld_r;
	assign wrDec = regDec(awAddr_r);
	assign bm = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= '0;
			wStrb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= fpil_pkg::RESP_OK;
		end else if (ce) begin
			if (awvalid & awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= awaddr;
			end
			if (wvalid & wready) begin
				wHeld_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (|wrDec) ? fpil_pkg::RESP_OK : fpil_pkg::RESP_ERR;
			end else if (bvalid_r & bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	// Control registers return to defaults on undervoltage or software reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlR <= fpil_pkg::CTRL_RST;
			limitR <= fpil_pkg::LIMIT_RST;
			maskR <= fpil_pkg::MASK_RST;
			genR <= fpil_pkg::GEN_RST;
		end else if (ce) begin
			if (softReset) begin
				ctrlR <= fpil_pkg::CTRL_RST;
				limitR <= fpil_pkg::LIMIT_RST;
				maskR <= fpil_pkg::MASK_RST;
				genR <= fpil_pkg::GEN_RST;
			end else if (doWrite) begin
				if (wrDec[0]) ctrlR <= (ctrlR & ~bm[7:0]) | (wData_r[7:0] & bm[7:0]);
				if (wrDec[1]) limitR <= (limitR & ~bm[7:0]) | (wData_r[7:0] & bm[7:0]);
				if (wrDec[4]) maskR <= (maskR & ~bm[1:0]) | (wData_r[1:0] & bm[1:0]);
				if (wrDec[5]) genR <= (genR & ~bm[10:0]) | (wData_r[10:0] & bm[10:0]);
			end
		end
	end
	assign liveV = {pgGood, eccDouble_r, eccSingle_r, sdLive, ovpLive, warnLive, convRun, climitLive};
	always_comb begin
		rdNxt = '0;
		case (regDec(araddr))
			6'h01: rdNxt = {24'h0, ctrlR};
			6'h02: rdNxt = {24'h0, limitR};
			6'h04: rdNxt = {20'h0, flagsR};
			6'h08: rdNxt = {15'h0, liveV};
			6'h10: rdNxt = {30'h0, maskR};
			6'h20: rdNxt = {21'h0, genR};
			default: rdNxt = '0;
		endcase
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= fpil_pkg::RESP_OK;
		end else if (ce) begin
			if (arvalid & arready) begin
				rvalid_r <= 1'b1;
				rdata_r <= rdNxt;
				rresp_r <= (|regDec(araddr)) ? fpil_pkg::RESP_OK : fpil_pkg::RESP_ERR;
			end else if (rvalid_r & rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || !ce);
	sequence clrShort0;
		flagsR.shortF[0] && flagClr.shortF[0];
	endsequence
	sequence freeToRun0;
		!blockAll && ctrlR.convEn[0] && !flagsR.shortF[0];
	endsequence
	irq_pin_a: assert property ((|(flagsR & irqEn)) |=> !irqOutN) else $error("irq pin not low");
	irq_release_a: assert property (!(|(flagsR & irqEn)) |=> irqOutN) else $error("irq pin stuck low");
	short_stop_a: assert property (fault[0] |=> flagsR.shortF[0] && flagsR.buckGroup && !convRun[0]) else $error("short not handled");
	restart_seq_a: assert property (clrShort0 ##1 freeToRun0 |=> convRun[0]) else $error("no restart");
	ovp_hold_a: assert property (ovpLive && flagClr.overVolt |=> flagsR.overVolt) else $error("ovp flag cleared");
	ovp_off_a: assert property (ovpLive |=> convRun == 3'h0 && genoutO == 3'h0) else $error("ovp outputs on");
	hot_block_a: assert property (flagsR.hotShut |=> convRun == 3'h0) else $error("run while hot");
	hard_low_a: assert property (ana.boostHardLow |=> switchHiZ[2]) else $error("boost still switching");
	no_discharge_a: assert property (!ctrlR.dischargeEn[1] && !ovpLive && !uvlo |=> !dischargeOn[1]) else $error("discharge on");
	ramp_quiet_a: assert property (buckRamp[0] && !flagsR.climit[0] && !flagClr.climit[0] |=> !flagsR.climit[0])
		else $error("ramp limit flag");
	warn_set_a: assert property ($rose(warnLive) |=> flagsR.hotWarn) else $error("warn flag missing");
endmodule : fpil_top

/* verilog/fpil_pkg.sv */
// Constants and types for the fault protection and interrupt logic
// Function
// - Buck peak current regulation for 20 us sets its flag, pulls interrupt; live bit.
// - Buck current-limit flags are suppressed during start-up and voltage ramps.
// - Boost peak current regulation for 64 us sets its flag, pulls interrupt; live bit.
// - Buck output below threshold 1 ms after enable declares short, disables buck.
// - Buck feedback low continuously for 1 ms in normal operation disables it.
// - Boost output below input margin for 1 ms, also at start-up, disables boost.
// - Boost output at hard low level stops boost switching at once.
// - Short or overload sets short and group flags, clears running bit, interrupts.
// - Host clears short flag by writing one; enabled converter then restarts.
// - Thermal warning sets flag, interrupts, live bit, write-one clear, mask bit.
// - Protective disable puts switches high impedance; discharge only if enabled, except on overvoltage or undervoltage.
// - Overvoltage disables all, discharges, forces outputs low, flags, clears running bits; an open-drain output at high level is released, not driven low.
// - Overvoltage flag clear ignored while present; live bit; enables blocked.
// - Thermal shutdown disables converters at once, sets flag, interrupts, goes standby.
// - Shutdown flag held while hot; live bit; enables blocked while hot or pending.
// - Undervoltage disables all, discharges, enters shutdown; standby once supply returns.
// - After shutdown or software reset registers default, reset flag set if unmasked.
// - OTP banks use single-correct double-detect code with two sticky status bits.
// - Three general outputs with drive type, level and pin sequencing; function select on outputs 1 and 2.
// - Enable pins are only synchronised, both edges, without glitch filter.
// - Overvoltage detection debounced both edges by 1 us sampling counter.
// - Power-good monitors debounced both edges, buck 6 us, others 15 us.
package fpil_pkg;
	localparam int CLK_NS = 100;
	localparam int T_BUCK_CLIM_US = 20;
	localparam int T_BOOST_CLIM_US = 64;
	localparam int T_HOT_US = 20;
	localparam int T_OVP_US = 1;
	localparam int T_PG_FAST_US = 6;
	localparam int T_PG_SLOW_US = 15;
	localparam int T_QUAL_MS = 1;
	localparam int CYC_QUAL = (T_QUAL_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int DB_OVP = 0;
	localparam int DB_SD = 2;
	localparam int DB_CLIM = 3;
	localparam int DB_BOOST = 5;
	localparam int DB_PGF = 6;
	localparam int DB_PGS = 8;
	localparam int NDB = 12;
	localparam int OTP_CW = 48;
	localparam int SYN_W = 6;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_LIMIT = 8'h04;
	localparam logic [7:0] A_FLAGS = 8'h08;
	localparam logic [7:0] A_LIVE = 8'h0c;
	localparam logic [7:0] A_MASK = 8'h10;
	localparam logic [7:0] A_GEN = 8'h14;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef struct packed {
		logic [2:0] seqPin;
		logic [3:0] slowPg;
		logic [1:0] buckPg;
		logic underVolt;
		logic overVolt;
		logic hotShut;
		logic hotWarn;
		logic boostHardLow;
		logic boostBelowIn;
		logic [1:0] fbLow;
		logic boostPeak;
		logic [1:0] buckPeak;
	} fpil_ana_t;
	typedef struct packed {
		logic hotSel;
		logic swReset;
		logic [2:0] dischargeEn;
		logic [2:0] convEn;
	} fpil_ctrl_t;
	typedef struct packed {
		logic rstFlag;
		logic boostGroup;
		logic buckGroup;
		logic hotShut;
		logic overVolt;
		logic hotWarn;
		logic [2:0] shortF;
		logic [2:0] climit;
	} fpil_flags_t;
	typedef struct packed {
		logic out2Sel;
		logic out1Sel;
		logic [2:0] seqCtrl;
		logic [2:0] driveType;
		logic [2:0] level;
	} fpil_gen_t;
	typedef struct packed {
		logic rstMask;
		logic hotMask;
	} fpil_mask_t;
	typedef enum logic [2:0] {
		ST_SHUTDOWN = 3'b001,
		ST_STANDBY = 3'b010,
		ST_ACTIVE = 3'b100
	} fpil_state_t;
	localparam fpil_ctrl_t CTRL_RST = 8'h00;
	localparam logic [7:0] LIMIT_RST = 8'h00;
	localparam fpil_mask_t MASK_RST = 2'h0;
	localparam fpil_gen_t GEN_RST = 11'h000;
	localparam fpil_flags_t FLAGS_SRST = 12'h800;
	function automatic int usCyc(input int us);
		return (us * 1000 + CLK_NS - 1) / CLK_NS;
	endfunction : usCyc
	function automatic int dbLen(input int i);
		if (i == DB_OVP) return usCyc(T_OVP_US);
		if (i < DB_CLIM) return usCyc(T_HOT_US);
		if (i < DB_BOOST) return usCyc(T_BUCK_CLIM_US);
		if (i < DB_PGF) return usCyc(T_BOOST_CLIM_US);
		if (i < DB_PGS) return usCyc(T_PG_FAST_US);
		return usCyc(T_PG_SLOW_US);
	endfunction : dbLen
endpackage : fpil_pkg

/* bench/fpil_host.sv */
// Host model: AXI4-Lite master that services the flag register
`timescale 1ns/100ps
module fpil_host (
	input wire logic clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
	end
	// Each task starts one edge late so no signal is driven twice in a step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic ack(input logic [31:0] m);
		logic [1:0] r;
		wr(fpil_pkg::A_FLAGS, m, r);
	endtask : ack
endmodule : fpil_host

/* bench/tb_top.sv */
// Bench top: injects faults and checks flags, pins and converters
`timescale 1ns/100ps
module tb_top;
	localparam int QC = 20;
	logic clk, sysRst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irqOutN;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [31:0] wdata, rdata, seed;
	logic [1:0] bresp, rresp, rsp, buckRamp;
	logic [2:0] convRun, switchHiZ, dischargeOn, genoutO, genoutOe;
	logic ce, otpCodeValid;
	logic [47:0] otpCode, otpFixed, code;
	logic [5:0] pgGood;
	fpil_pkg::fpil_ana_t anaIn;
	fpil_pkg::fpil_state_t deviceState;
	int nMismatch, checkCount, cyc;
	fpil_top #(.QUAL_CYC(QC)) dut (.clk(clk), .sys_rst(sysRst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .anaIn(anaIn), .buckRamp(buckRamp), .otpCode(otpCode),
		.otpCodeValid(otpCodeValid), .irqOutN(irqOutN), .convRun(convRun), .switchHiZ(switchHiZ),
		.dischargeOn(dischargeOn), .buckPeakLimitSel(), .boostPeakLimitSel(), .hotWarningThresholdSel(),
		.genoutO(genoutO), .genoutOe(genoutOe), .out1FunctionSel(), .out2FunctionSel(), .pgGood(pgGood),
		.deviceState(deviceState), .otpFixed(otpFixed));
	fpil_host host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [31:0] shortFlags(input int i);
		return (32'h1 << (3 + i)) | ((i == 2) ? 32'h400 : 32'h200);
	endfunction : shortFlags
	// Clean codeword: check bits at powers of two, bit 0 makes parity even
	function automatic logic [47:0] eccEnc(input logic [47:0] w);
		logic [47:0] c;
		logic [5:0] s;
		c = w;
		s = '0;
		for (int i = 1; i < 48; i++) begin
			if (w[i]) s = s ^ 6'(i);
		end
		for (int k = 0; k < 6; k++) begin
			if (s[k]) c[1 << k] = ~c[1 << k];
		end
		c[0] = ^c[47:1];
		return c;
	endfunction : eccEnc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask : rdChk
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask : cycles
	task automatic tallyAndFinish();
		if (nMismatch == 0 && checkCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tallyAndFinish
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Hang guard, far above the roughly 2800 cycles of the run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			nMismatch++;
			tallyAndFinish();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{nMismatch, checkCount, cyc} = '0;
		seed = 32'h0000000a;
		sysRst = 1'b1;
		anaIn = '0;
		buckRamp = 2'h0;
		otpCode = '0;
		otpCodeValid = 1'b0;
		ce = 1'b1;
		repeat (6) @(posedge clk);
		sysRst <= 1'b0;
		cycles(3);
		chk(32'(irqOutN), 32'h0);
		rdChk(fpil_pkg::A_FLAGS, 32'h800, fpil_pkg::RESP_OK);
		host.ack(32'h800);
		cycles(3);
		chk(32'(irqOutN), 32'h1);
		seed = xs(seed);
		code = eccEnc({seed[15:0], seed});
		otpCode <= code ^ (48'h1 << seed[4:0]);
		otpCodeValid <= 1'b1;
		cycles(1);
		otpCodeValid <= 1'b0;
		cycles(2);
		chk(otpFixed[31:0], code[31:0]);
		chk(32'(otpFixed[47:32]), 32'(code[47:32]));
		rdChk(fpil_pkg::A_LIVE, 32'h200, fpil_pkg::RESP_OK);
		otpCode <= code ^ (48'h1 << seed[4:0]) ^ (48'h10000 << seed[4:0]);
		otpCodeValid <= 1'b1;
		cycles(1);
		otpCodeValid <= 1'b0;
		rdChk(fpil_pkg::A_LIVE, 32'h600, fpil_pkg::RESP_OK);
		rdChk(8'h40, 32'h0, fpil_pkg::RESP_ERR);
		host.wr(fpil_pkg::A_GEN, 32'h7, rsp);
		host.wr(fpil_pkg::A_CTRL, 32'h9, rsp);
		cycles(QC + 10);
		chk(32'(genoutO), 32'h7);
		chk(32'(genoutOe), 32'h7);
		chk(32'(convRun), 32'h1);
		// Frozen clock enable: an overvoltage pulse must go unseen
		ce <= 1'b0;
		anaIn.overVolt <= 1'b1;
		cycles(20);
		ce <= 1'b1;
		anaIn.overVolt <= 1'b0;
		cycles(8);
		chk(32'(convRun), 32'h1);
		// Random glitches, each shorter than the overload window
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			anaIn.fbLow[0] <= 1'b1;
			cycles(1 + seed[3:0]);
			anaIn.fbLow[0] <= 1'b0;
			cycles(8);
		end
		chk(32'(convRun), 32'h1);
		anaIn.fbLow[0] <= 1'b1;
		cycles(QC + 8);
		chk(32'(convRun), 32'h0);
		chk(32'(switchHiZ), 32'h7);
		chk(32'(dischargeOn), 32'h1);
		chk(32'(irqOutN), 32'h0);
		rdChk(fpil_pkg::A_FLAGS, shortFlags(0), fpil_pkg::RESP_OK);
		anaIn.fbLow[0] <= 1'b0;
		cycles(8);
		host.ack(shortFlags(0));
		cycles(QC + 4);
		chk(32'(convRun), 32'h1);
		chk(32'(irqOutN), 32'h1);
		buckRamp <= 2'h1;
		anaIn.buckPeak[0] <= 1'b1;
		cycles(215);
		buckRamp <= 2'h0;
		anaIn.buckPeak[0] <= 1'b0;
		cycles(215);
		rdChk(fpil_pkg::A_FLAGS, 32'h0, fpil_pkg::RESP_OK);
		anaIn.buckPeak[0] <= 1'b1;
		cycles(215);
		rdChk(fpil_pkg::A_FLAGS, 32'h1, fpil_pkg::RESP_OK);
		anaIn.buckPeak[0] <= 1'b0;
		cycles(215);
		host.ack(32'h1);
		host.wr(fpil_pkg::A_MASK, 32'h1, rsp);
		anaIn.hotWarn <= 1'b1;
		anaIn.slowPg <= seed[5:2];
		anaIn.buckPg <= seed[1:0];
		cycles(215);
		chk(32'(irqOutN), 32'h1);
		chk(32'(pgGood), 32'(seed[5:0]));
		rdChk(fpil_pkg::A_LIVE, {15'h0, seed[5:0], 11'h648}, fpil_pkg::RESP_OK);
		host.wr(fpil_pkg::A_MASK, 32'h0, rsp);
		cycles(3);
		chk(32'(irqOutN), 32'h0);
		anaIn.hotWarn <= 1'b0;
		cycles(215);
		host.ack(32'h40);
		anaIn.overVolt <= 1'b1;
		cycles(20);
		chk(32'(convRun), 32'h0);
		chk(32'(genoutO), 32'h0);
		chk(32'(dischargeOn), 32'h7);
		host.ack(32'h80);
		rdChk(fpil_pkg::A_FLAGS, 32'h80, fpil_pkg::RESP_OK);
		anaIn.overVolt <= 1'b0;
		cycles(20);
		chk(32'(convRun), 32'h0);
		host.ack(32'h80);
		cycles(QC + 4);
		chk(32'(convRun), 32'h1);
		anaIn.hotShut <= 1'b1;
		cycles(215);
		chk(32'(convRun), 32'h0);
		chk(32'(deviceState), 32'(fpil_pkg::ST_STANDBY));
		anaIn.hotShut <= 1'b0;
		cycles(215);
		host.ack(32'h100);
		host.wr(fpil_pkg::A_CTRL, 32'h5, rsp);
		chk(32'(rsp), 32'(fpil_pkg::RESP_OK));
		anaIn.boostPeak <= 1'b1;
		cycles(600);
		rdChk(fpil_pkg::A_FLAGS, 32'h0, fpil_pkg::RESP_OK);
		cycles(60);
		rdChk(fpil_pkg::A_FLAGS, 32'h4, fpil_pkg::RESP_OK);
		anaIn.boostPeak <= 1'b0;
		anaIn.boostHardLow <= 1'b1;
		cycles(8);
		chk(32'(switchHiZ), 32'h6);
		chk(32'(convRun), 32'h5);
		cycles(QC + 4);
		chk(32'(convRun), 32'h1);
		rdChk(fpil_pkg::A_FLAGS, shortFlags(2) | 32'h4, fpil_pkg::RESP_OK);
		anaIn.boostHardLow <= 1'b0;
		anaIn.underVolt <= 1'b1;
		cycles(8);
		chk(32'(deviceState), 32'(fpil_pkg::ST_SHUTDOWN));
		anaIn.underVolt <= 1'b0;
		cycles(8);
		chk(32'(deviceState), 32'(fpil_pkg::ST_STANDBY));
		rdChk(fpil_pkg::A_FLAGS, 32'h800, fpil_pkg::RESP_OK);
		tallyAndFinish();
	end
endmodule : tb_top
